/* design/dpsp_codec.v */
/*
 * Companding codec: mu-law / A-law encoder and decoder, purely
 * combinational. Linear words are sign-magnitude, sign in bit 15,
 * magnitude in the low bits; mu-law magnitudes carry the bias of 33.
 */
`include "dpsp_defs.vh"
module dpsp_codec (
    // Law selection
    input  wire        law,
    // Encoder side
    input  wire [15:0] lin_in,
    output wire [7:0]  enc_out,
    // Decoder side
    input  wire [7:0]  log_in,
    output wire [15:0] lin_out
);
    // Segment = position of the leading one above the chord base
    function [2:0] seg_of;
        input [12:0] m;
        integer i;
        begin
            seg_of = 3'h0;
            for (i = 1; i < 8; i = i + 1)
                if (m[i + 5])
                    seg_of = i[2:0];
        end
    endfunction

    wire [12:0] mag_u = lin_in[12:0];
    wire [12:0] mag_a = {lin_in[11:0], 1'b0};
    wire [12:0] mag   = law ? mag_a : mag_u;
    wire [2:0]  seg   = seg_of(mag);
    // A-law segment 0 keeps the step of segment 1; segment 7 needs an 8-bit shift
    wire [12:0] shf   = mag >> ({1'b0, seg} + ((law && seg == 3'h0) ? 4'h2 : 4'h1));
    wire        sgn   = lin_in[`DPSP_SIGN_BIT];

    // Encoder; A-law inverts even bits, mu-law inverts all
    assign enc_out = law ? ({~sgn, seg, shf[3:0]} ^ 8'h55)
                         : ~{sgn, seg, shf[3:0]};

    // Decoder fields after undoing the line inversion
    wire [7:0]  c   = law ? (log_in ^ 8'h55) : ~log_in;
    wire [2:0]  ds  = c[6:4];
    wire [13:0] man = {9'h000, c[3:0], 1'b0} + 14'h0021;
    wire [13:0] du  = man << ds;
    wire [13:0] da0 = {9'h000, c[3:0], 1'b1};
    wire [13:0] da  = (ds == 3'h0) ? da0 : (man << (ds - 3'h1));
    wire [12:0] dm  = law ? da[12:0] : du[12:0];

    // Expansion back to sign-magnitude linear; line bit 7 high is positive
    assign lin_out = {~log_in[7], 2'b00, dm};
endmodule // dpsp_codec

/* design/dpsp_defs.vh */
/*
 * Constants for the dual PCM serial port with companding: register map,
 * control field positions, reset values and serial timing.
 * Assumes a 32-bit Avalon-MM slave bus with byte addresses.
 */
`ifndef DPSP_DEFS_VH
`define DPSP_DEFS_VH

// ********************
// Register map (byte addresses)
// ********************
`define DPSP_OFS_CTRL       4'h0
`define DPSP_OFS_PORT1      4'h4
`define DPSP_OFS_UPPER      4'h8

// ********************
// Control fields
// ********************
`define DPSP_B_RXFLAG       1
`define DPSP_B_INTFLAG      3
`define DPSP_B_UPSEL        8
`define DPSP_B_FRSRC        9
`define DPSP_B_SEREN        11
`define DPSP_B_ENCSEL       12
`define DPSP_B_DECSEL       13
`define DPSP_B_LAW          14
`define DPSP_B_SCLKDIR      15
`define DPSP_U_DIV_HI       7
`define DPSP_U_PRE_LO       8
`define DPSP_U_PRE_HI       11
`define DPSP_U_LONG         12
`define DPSP_SIGN_BIT       15
`define DPSP_RST_SCLKDIR    1'b1
`define DPSP_RST_SEREN      1'b0
`define DPSP_RST_UPPER      13'h0000

// ********************
// Serial timing
// ********************
`define DPSP_BITS           4'h8
`define DPSP_LONG_WIDTH     9'h008
`define DPSP_DIV_OFFSET     9'h002

`endif

/* design/dpsp_top.v */
/*
 * Dual-channel PCM serial port with companding. Holds control
 * registers, receive shifters and holding registers, two-stage transmit
 * FIFO, framing logic, serial clock prescaler and frame divider.
 * Assumes an Avalon-MM master on MCLK and pin inputs synchronous to it.
 */
// Our own choices: the Avalon-MM register port and the placing of the registers.
`include "dpsp_defs.vh"
module dpsp_top #(
    parameter AW = 4
) (
    // Clock and reset
    input  wire          MCLK,
    input  wire          RST_N,
    // Avalon-MM slave
    input  wire [AW-1:0] AVS_ADDRESS,
    input  wire          AVS_READ,
    input  wire          AVS_WRITE,
    input  wire [31:0]   AVS_WRITEDATA,
    output reg  [31:0]   AVS_READDATA,
    output wire          AVS_WAITREQUEST,
    // Serial clock pin
    input  wire          SCLK_I,
    output reg           SCLK_O,
    output wire          SCLK_OE,
    // Serial data lines
    input  wire          RX_LINE_CH0,
    input  wire          RX_LINE_CH1,
    output reg           TX_LINE_CH0,
    output wire          TX_LINE_CH0_OE,
    output reg           TX_LINE_CH1,
    output wire          TX_LINE_CH1_OE,
    // Framing
    input  wire          EXT_RX_FRAME_N,
    input  wire          EXT_TX_FRAME_N,
    output reg           INTERNAL_FRAME_PULSE
);
    // Prescale ratio table, codes ascending onto ratios
    function [4:0] half_ratio;
        input [2:0] code;
        begin
            case (code)
                3'h0:    half_ratio = 5'h05;
                3'h1:    half_ratio = 5'h06;
                3'h2:    half_ratio = 5'h07;
                3'h3:    half_ratio = 5'h08;
                3'h4:    half_ratio = 5'h0A;
                3'h5:    half_ratio = 5'h0C;
                3'h6:    half_ratio = 5'h0E;
                default: half_ratio = 5'h10;
            endcase
        end
    endfunction

    // ********************
    // Control state
    // ********************
    reg        rx_frame_flag;
    reg        int_frame_flag;
    reg        upper_ctrl_select;
    reg        frame_source_select;
    reg        serial_enable;
    reg        encode_path_select;
    reg        decode_path_select;
    reg        law_select;
    reg        sclk_direction;
    reg [12:0] upper;
    wire [7:0] frame_divide_value   = upper[`DPSP_U_DIV_HI:0];
    wire [3:0] sclk_prescale_select = upper[`DPSP_U_PRE_HI:`DPSP_U_PRE_LO];
    wire       long_pulse           = upper[`DPSP_U_LONG];

    // ********************
    // Bus decode
    // ********************
    reg  rd_done;
    wire sel_ctrl  = (AVS_ADDRESS == `DPSP_OFS_CTRL);
    wire sel_port1 = (AVS_ADDRESS == `DPSP_OFS_PORT1);
    wire sel_upper = (AVS_ADDRESS == `DPSP_OFS_UPPER);
    wire wr_ctrl   = AVS_WRITE & sel_ctrl;
    wire wr_port1  = AVS_WRITE & sel_port1;
    wire wr_upper  = wr_port1 & upper_ctrl_select;
    wire wr_data   = wr_port1 & ~upper_ctrl_select;
    wire rd_accept = AVS_READ & rd_done;
    wire rd_port1  = rd_accept & sel_port1;

    // Reads wait one cycle so read data come from a register
    assign AVS_WAITREQUEST = AVS_READ & ~rd_done;

    // ********************
    // Serial clock: prescaler or pin
    // ********************
    reg  [4:0] pcnt;
    reg        sclk_q;
    wire [4:0] half     = half_ratio(sclk_prescale_select[2:0]);
    wire       gen_tick = (pcnt == half - 5'h01);
    wire       sclk_rise = sclk_direction ? (SCLK_I & ~sclk_q)
                                          : (gen_tick & ~SCLK_O);
    wire       sclk_fall = sclk_direction ? (~SCLK_I & sclk_q)
                                          : (gen_tick & SCLK_O);

    // Output only while direction is output; ratio ignored as input
    assign SCLK_OE = ~sclk_direction;

    // Divider toggles the clock every half ratio of MCLK cycles
    always @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            pcnt   <= 5'h00;
            SCLK_O <= 1'b0;
            sclk_q <= 1'b0;
        end else begin
            sclk_q <= SCLK_I;
            if (gen_tick || pcnt >= half) begin
                pcnt   <= 5'h00;
                SCLK_O <= ~SCLK_O;
            end else begin
                pcnt <= pcnt + 5'h01;
            end
        end
    end

    // ********************
    // Internal frame generator
    // ********************
    reg  [8:0] fcnt;
    reg  [7:0] div_lat;
    wire [8:0] period    = {1'b0, div_lat} + `DPSP_DIV_OFFSET;
    wire       wrap      = (fcnt >= period - 9'h001);
    wire [8:0] next_fcnt = wrap ? 9'h000 : fcnt + 9'h001;
    wire       next_pulse = long_pulse ? (next_fcnt < `DPSP_LONG_WIDTH)
                                       : (next_fcnt == 9'h000);
    // Edges of the active-high pulse, coincident with a clock rise
    wire       int_rise = sclk_rise & next_pulse & ~INTERNAL_FRAME_PULSE;
    wire       int_fall = sclk_rise & ~next_pulse & INTERNAL_FRAME_PULSE;

    // Rate is clock over divide plus two; divide caught at wrap
    always @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            fcnt                 <= 9'h000;
            div_lat              <= 8'h00;
            INTERNAL_FRAME_PULSE <= 1'b0;
        end else if (sclk_rise) begin
            fcnt                 <= next_fcnt;
            INTERNAL_FRAME_PULSE <= next_pulse;
            if (wrap)
                div_lat <= frame_divide_value;
        end
    end

    // ********************
    // Frame multiplexer
    // ********************
    reg        erx_q;
    reg        etx_q;
    reg  [3:0] ibits;
    wire       erx_fall = erx_q & ~EXT_RX_FRAME_N;
    wire       erx_rise = ~erx_q & EXT_RX_FRAME_N;
    wire       etx_fall = etx_q & ~EXT_TX_FRAME_N;
    // Short pulse: start on its fall; long pulse: start on its rise
    wire       int_start = long_pulse ? int_rise : int_fall;
    // Short mode finishes on the eighth falling edge after the start
    wire       short_done = ~long_pulse & sclk_fall & (ibits == 4'h1);
    wire       int_done   = long_pulse ? int_fall : short_done;
    wire       rx_start = frame_source_select ? int_start : erx_fall;
    wire       rx_load  = frame_source_select ? int_done : erx_rise;
    wire       tx_load  = frame_source_select ? int_start : etx_fall;

    // Edge history of the external frame pins, bit count for short mode
    always @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            erx_q <= 1'b1;
            etx_q <= 1'b1;
            ibits <= 4'h0;
        end else begin
            erx_q <= EXT_RX_FRAME_N;
            etx_q <= EXT_TX_FRAME_N;
            if (int_start)
                ibits <= `DPSP_BITS;
            else if (sclk_fall && ibits != 4'h0)
                ibits <= ibits - 4'h1;
        end
    end

    // ********************
    // Receive path
    // ********************
    reg  [7:0] rx_sh0;
    reg  [7:0] rx_sh1;
    reg  [3:0] rx_cnt;
    reg  [7:0] rx_holding_ch0;
    reg  [7:0] rx_holding_ch1;
    reg        rd_ptr;
    wire       rx_shift = sclk_fall & (rx_cnt != 4'h0);
    wire [7:0] next_sh0 = rx_shift ? {rx_sh0[6:0], RX_LINE_CH0} : rx_sh0;
    wire [7:0] next_sh1 = rx_shift ? {rx_sh1[6:0], RX_LINE_CH1} : rx_sh1;

    // Frame start gates eight falling edges into the shifters, MSB first
    always @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            rx_sh0         <= 8'h00;
            rx_sh1         <= 8'h00;
            rx_cnt         <= 4'h0;
            rx_holding_ch0 <= 8'h00;
            rx_holding_ch1 <= 8'h00;
            rd_ptr         <= 1'b0;
        end else begin
            rx_sh0 <= next_sh0;
            rx_sh1 <= next_sh1;
            if (rx_start)
                rx_cnt <= `DPSP_BITS;
            else if (rx_shift)
                rx_cnt <= rx_cnt - 4'h1;
            // Holding registers load only while the port is enabled
            if (rx_load && serial_enable) begin
                rx_holding_ch0 <= next_sh0;
                rx_holding_ch1 <= next_sh1;
            end
            // Each frame restarts the read order at channel 0
            if (rx_load)
                rd_ptr <= 1'b0;
            else if (rd_port1)
                rd_ptr <= 1'b1;
        end
    end

    // ********************
    // Transmit FIFO and shifters
    // ********************
    reg  [7:0] fifo0;
    reg  [7:0] fifo1;
    reg        wr_seen;
    reg  [7:0] tx_shifter_ch0;
    reg  [7:0] tx_shifter_ch1;
    reg  [3:0] tx_cnt;
    reg        tx_busy;
    wire [7:0] enc_out;
    wire [7:0] fifo_input_selector;
    wire       tx_shifter_load = tx_load;

    // Encoder runs on every write; select bit chooses what enters stage 0
    assign fifo_input_selector = encode_path_select ? enc_out : AVS_WRITEDATA[7:0];

    // Outputs float unless enabled and shifting
    assign TX_LINE_CH0_OE = serial_enable & tx_busy;
    assign TX_LINE_CH1_OE = serial_enable & tx_busy;

    // FIFO fills regardless of enable; frame edge copies it out
    always @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            fifo0          <= 8'h00;
            fifo1          <= 8'h00;
            wr_seen        <= 1'b0;
            tx_shifter_ch0 <= 8'h00;
            tx_shifter_ch1 <= 8'h00;
            tx_cnt         <= 4'h0;
            tx_busy        <= 1'b0;
            TX_LINE_CH0    <= 1'b0;
            TX_LINE_CH1    <= 1'b0;
        end else begin
            if (wr_data) begin
                fifo0 <= fifo_input_selector;
                if (wr_seen && !tx_shifter_load)
                    fifo1 <= fifo0;
            end
            // A write in the load cycle opens the next interval
            if (tx_shifter_load)
                wr_seen <= wr_data;
            else if (wr_data)
                wr_seen <= 1'b1;
            // Both channels always load; channel 1 keeps its stage
            if (tx_shifter_load && sclk_rise) begin
                TX_LINE_CH0    <= fifo0[7];
                TX_LINE_CH1    <= fifo1[7];
                tx_shifter_ch0 <= {fifo0[6:0], 1'b0};
                tx_shifter_ch1 <= {fifo1[6:0], 1'b0};
                tx_cnt         <= `DPSP_BITS - 4'h1;
                tx_busy        <= 1'b1;
            end else if (tx_shifter_load) begin
                tx_shifter_ch0 <= fifo0;
                tx_shifter_ch1 <= fifo1;
                tx_cnt         <= `DPSP_BITS;
            end else if (sclk_rise) begin
                if (tx_cnt != 4'h0) begin
                    TX_LINE_CH0    <= tx_shifter_ch0[7];
                    TX_LINE_CH1    <= tx_shifter_ch1[7];
                    tx_shifter_ch0 <= {tx_shifter_ch0[6:0], 1'b0};
                    tx_shifter_ch1 <= {tx_shifter_ch1[6:0], 1'b0};
                    tx_cnt         <= tx_cnt - 4'h1;
                    tx_busy        <= 1'b1;
                end else begin
                    tx_busy <= 1'b0;
                end
            end
        end
    end

    // ********************
    // Read path and codec
    // ********************
    wire [15:0] lin_out;
    // Parallel mode can only see stage 0; stage 1 is never readable
    wire [7:0]  read_path_selector = !serial_enable ? fifo0
                                   : (rd_ptr ? rx_holding_ch1 : rx_holding_ch0);
    // Straight byte or expanded linear word
    wire [31:0] port1_data = decode_path_select ? {16'h0000, lin_out}
                                                : {24'h000000, read_path_selector};

    dpsp_codec u_codec (
        .law     (law_select),
        .lin_in  (AVS_WRITEDATA[15:0]),
        .enc_out (enc_out),
        .log_in  (read_path_selector),
        .lin_out (lin_out)
    );

    // ********************
    // Register file
    // ********************
    wire [15:0] ctrl_word;
    assign ctrl_word = {sclk_direction, law_select, decode_path_select,
                        encode_path_select, serial_enable, 1'b0,
                        frame_source_select, upper_ctrl_select, 4'h0,
                        int_frame_flag, 1'b0, rx_frame_flag, 1'b0};

    // Read data registered in the wait cycle; unmapped reads return zero
    always @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            rd_done      <= 1'b0;
            AVS_READDATA <= 32'h00000000;
        end else begin
            rd_done <= AVS_READ & ~rd_done;
            if (AVS_READ && !rd_done) begin
                if (sel_ctrl)
                    AVS_READDATA <= {16'h0000, ctrl_word};
                else if (sel_port1)
                    AVS_READDATA <= port1_data;
                else if (sel_upper)
                    AVS_READDATA <= {19'h00000, upper};
                else
                    AVS_READDATA <= 32'h00000000;
            end
        end
    end

    // Control writes; a flag event wins over a clearing write
    always @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            rx_frame_flag       <= 1'b0;
            int_frame_flag      <= 1'b0;
            upper_ctrl_select   <= 1'b0;
            frame_source_select <= 1'b0;
            serial_enable       <= `DPSP_RST_SEREN;
            encode_path_select  <= 1'b0;
            decode_path_select  <= 1'b0;
            law_select          <= 1'b0;
            sclk_direction      <= `DPSP_RST_SCLKDIR;
            upper               <= `DPSP_RST_UPPER;
        end else begin
            if (wr_ctrl) begin
                upper_ctrl_select   <= AVS_WRITEDATA[`DPSP_B_UPSEL];
                frame_source_select <= AVS_WRITEDATA[`DPSP_B_FRSRC];
                serial_enable       <= AVS_WRITEDATA[`DPSP_B_SEREN];
                encode_path_select  <= AVS_WRITEDATA[`DPSP_B_ENCSEL];
                decode_path_select  <= AVS_WRITEDATA[`DPSP_B_DECSEL];
                law_select          <= AVS_WRITEDATA[`DPSP_B_LAW];
                sclk_direction      <= AVS_WRITEDATA[`DPSP_B_SCLKDIR];
            end
            rx_frame_flag  <= erx_rise
                | (wr_ctrl ? AVS_WRITEDATA[`DPSP_B_RXFLAG] : rx_frame_flag);
            int_frame_flag <= int_done
                | (wr_ctrl ? AVS_WRITEDATA[`DPSP_B_INTFLAG] : int_frame_flag);
            if (wr_upper)
                upper <= AVS_WRITEDATA[12:0];
        end
    end
endmodule // dpsp_top

/* verif/dpsp_far.sv */
/* Far-side codec model: sends one byte a channel after each internal
   frame and captures what the port sends. Assumes short framing. */
module dpsp_far (
    // Clock and link
    input  wire       mclk,
    input  wire       rst_n,
    input  wire       sck,
    input  wire       frame,
    input  wire       tx0,
    input  wire       tx1,
    // Bytes to send, bytes heard
    input  wire [7:0] b0,
    input  wire [7:0] b1,
    output reg        rx0,
    output reg        rx1,
    output reg  [7:0] cap0,
    output reg  [7:0] cap1
);
    timeunit 1ns;
    timeprecision 1ns;
    reg       sck_d, fr_d;
    reg [3:0] left;
    reg [7:0] s0, s1;
    // ********************
    // Bit engine
    // ********************
    // Idle lines toggle: a stray sample sees no stale bit
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            {sck_d, fr_d, left, s0, s1, rx0, rx1, cap0, cap1} <= 40'h0;
        end else begin
            sck_d <= sck;
            fr_d <= frame;
            if (fr_d && !frame) begin
                left <= 4'h8;
                {rx0, s0, rx1, s1} <= {b0[7], b0, b1[7], b1};
            end else if (left == 4'h0) begin
                {rx0, rx1} <= ~{rx0, rx1};
            end else if (sck_d && !sck) begin
                left <= left - 4'h1;
                {cap0, cap1} <= {cap0[6:0], tx0, cap1[6:0], tx1};
            end else if (sck && !sck_d) begin
                {rx0, s0, rx1, s1} <= {s0[6], s0[6:0], 1'b0, s1[6], s1[6:0], 1'b0};
            end
        end
    end
endmodule // dpsp_far

/* verif/dpsp_sva.sv */
/* Port checker for dpsp_top, bound to every instance.
   Assumes serial clock edges are seen against MCLK, one cycle late. */
module dpsp_sva #(parameter AW = 4) (
    // Clock and bus
    input wire          MCLK,
    input wire          RST_N,
    input wire [AW-1:0] AVS_ADDRESS,
    input wire          AVS_READ,
    input wire [31:0]   AVS_READDATA,
    input wire          AVS_WAITREQUEST,
    // Serial pins
    input wire          SCLK_I,
    input wire          SCLK_O,
    input wire          SCLK_OE,
    input wire          TX_LINE_CH0,
    input wire          TX_LINE_CH0_OE,
    input wire          TX_LINE_CH1_OE,
    input wire          INTERNAL_FRAME_PULSE
);
    timeunit 1ns;
    timeprecision 1ns;
    // ********************
    // Edge tracking
    // ********************
    wire      sck = SCLK_OE ? SCLK_O : SCLK_I;
    reg       sck_d, fp_d;
    reg [3:0] rises;
    wire      rise = sck & ~sck_d;
    // Rises while driving since the last frame edge; a new frame restarts the shifter
    always @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            {sck_d, fp_d} <= 2'h0;
            rises         <= 4'h0;
        end else begin
            {sck_d, fp_d} <= {sck, INTERNAL_FRAME_PULSE};
            if (!TX_LINE_CH0_OE)
                rises <= 4'h0;
            else
                rises <= (fp_d != INTERNAL_FRAME_PULSE) ? {3'h0, rise} : rises + {3'h0, rise};
        end
    end
    default clocking @(posedge MCLK); endclocking
    default disable iff (!RST_N);
    property p_rd; AVS_READ && AVS_WAITREQUEST |=> !AVS_WAITREQUEST; endproperty
    a_rd: assert property (p_rd) else $error("read wait too long");
    property p_unm; AVS_READ && !AVS_WAITREQUEST && (AVS_ADDRESS[1:0] != 2'h0
        || AVS_ADDRESS > 'h8) |-> AVS_READDATA == 32'h0; endproperty
    a_unm: assert property (p_unm) else $error("unmapped read not zero");
    property p_same; TX_LINE_CH0_OE == TX_LINE_CH1_OE; endproperty
    a_same: assert property (p_same) else $error("channel enables differ");
    property p_len; TX_LINE_CH0_OE |-> rises < 4'h9; endproperty
    a_len: assert property (p_len) else $error("transmit longer than 8 bits");
    property p_bit; TX_LINE_CH0_OE && $changed(TX_LINE_CH0)
        |-> rise || $past(rise) || $past(rise, 2); endproperty
    a_bit: assert property (p_bit) else $error("bit moved off a rise");
    property p_fr; $changed(INTERNAL_FRAME_PULSE)
        |-> rise || $past(rise) || $past(rise, 2); endproperty
    a_fr: assert property (p_fr) else $error("frame moved off a rise");
    property p_sck; SCLK_OE && $changed(SCLK_O) |=> $stable(SCLK_O) [*4]; endproperty
    a_sck: assert property (p_sck) else $error("serial clock too fast");
    property p_rst; $rose(RST_N) |-> !SCLK_OE && !TX_LINE_CH0_OE; endproperty
    a_rst: assert property (p_rst) else $error("pins driven after reset");
endmodule // dpsp_sva
bind dpsp_top dpsp_sva #(.AW(AW)) u_sva (.MCLK(MCLK), .RST_N(RST_N),
    .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ), .AVS_READDATA(AVS_READDATA),
    .AVS_WAITREQUEST(AVS_WAITREQUEST), .SCLK_I(SCLK_I), .SCLK_O(SCLK_O),
    .SCLK_OE(SCLK_OE), .TX_LINE_CH0(TX_LINE_CH0), .TX_LINE_CH0_OE(TX_LINE_CH0_OE),
    .TX_LINE_CH1_OE(TX_LINE_CH1_OE), .INTERNAL_FRAME_PULSE(INTERNAL_FRAME_PULSE));

/* verif/dpsp_top_test.sv */
/* Self-checking bench for dpsp_top with the far-side codec model.
   Assumes dpsp_top, dpsp_far and the bound checker are compiled. */
module dpsp_top_test;
    timeunit 1ns;
    timeprecision 1ns;
    // ********************
    // Pins and bookkeeping
    // ********************
    reg         MCLK, RST_N, AVS_READ, AVS_WRITE, SCLK_I, EXT_RX_FRAME_N, EXT_TX_FRAME_N;
    reg  [3:0]  AVS_ADDRESS;
    reg  [31:0] AVS_WRITEDATA, rdv;
    wire [31:0] AVS_READDATA;
    wire        AVS_WAITREQUEST, SCLK_O, SCLK_OE, RX_LINE_CH0, RX_LINE_CH1, TX_LINE_CH0;
    wire        TX_LINE_CH0_OE, TX_LINE_CH1, TX_LINE_CH1_OE, INTERNAL_FRAME_PULSE;
    wire [7:0]  cap0, cap1;
    reg         fr_d = 1'b0;
    int         mismatches = 0, cmp_count = 0, cyc = 0, t_r = 0, per = 0, wid = 0;
    int         oe_hits = 0, oe0;
    dpsp_top DUT (.MCLK(MCLK), .RST_N(RST_N), .AVS_ADDRESS(AVS_ADDRESS),
        .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE), .AVS_WRITEDATA(AVS_WRITEDATA),
        .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST), .SCLK_I(SCLK_I),
        .SCLK_O(SCLK_O), .SCLK_OE(SCLK_OE), .RX_LINE_CH0(RX_LINE_CH0),
        .RX_LINE_CH1(RX_LINE_CH1), .TX_LINE_CH0(TX_LINE_CH0), .TX_LINE_CH0_OE(TX_LINE_CH0_OE),
        .TX_LINE_CH1(TX_LINE_CH1), .TX_LINE_CH1_OE(TX_LINE_CH1_OE),
        .EXT_RX_FRAME_N(EXT_RX_FRAME_N), .EXT_TX_FRAME_N(EXT_TX_FRAME_N),
        .INTERNAL_FRAME_PULSE(INTERNAL_FRAME_PULSE));
    // Undriven transmit lines reach the model as z, so a silent channel fails
    dpsp_far far (.mclk(MCLK), .rst_n(RST_N), .sck(SCLK_OE ? SCLK_O : SCLK_I),
        .frame(INTERNAL_FRAME_PULSE), .tx0(TX_LINE_CH0_OE ? TX_LINE_CH0 : 1'bz),
        .tx1(TX_LINE_CH1_OE ? TX_LINE_CH1 : 1'bz), .b0(8'h96), .b1(8'h5A),
        .rx0(RX_LINE_CH0), .rx1(RX_LINE_CH1), .cap0(cap0), .cap1(cap1));
    // Clock, frame period and width stamps, enable activity
    initial begin
        MCLK = 1'b0;
        forever #50 MCLK = ~MCLK;
    end
    always @(posedge MCLK) begin
        cyc <= cyc + 1;
        fr_d <= INTERNAL_FRAME_PULSE;
        if (INTERNAL_FRAME_PULSE && !fr_d) begin
            per <= cyc - t_r;
            t_r <= cyc;
        end
        if (!INTERNAL_FRAME_PULSE && fr_d) wid <= cyc - t_r;
        if (TX_LINE_CH0_OE === 1'b1) oe_hits <= oe_hits + 1;
    end
    // ********************
    // Shared tasks
    // ********************
    task chk(input [31:0] got, input [31:0] exp);
        cmp_count = cmp_count + 1;
        if (got !== exp) begin
            mismatches = mismatches + 1;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // One bus access, held until waitrequest is sampled low
    task bus(input w, input [3:0] a, input [31:0] d);
        @(posedge MCLK);
        AVS_ADDRESS <= a;
        AVS_WRITEDATA <= d;
        AVS_WRITE <= w;
        AVS_READ <= !w;
        @(posedge MCLK);
        while (AVS_WAITREQUEST !== 1'b0) @(posedge MCLK);
        rdv = AVS_READDATA;
        AVS_WRITE <= 1'b0;
        AVS_READ <= 1'b0;
    endtask
    task rc(input [3:0] a, input [31:0] exp);
        bus(1'b0, a, 32'h0);
        chk(rdv, exp);
    endtask
    // Upper word goes through the data port with the redirect bit set
    task upper(input [31:0] d);
        bus(1'b1, 4'h0, 32'h0B00);
        bus(1'b1, 4'h4, d);
        bus(1'b1, 4'h0, 32'h0A00);
    endtask
    task nxt;
        @(posedge INTERNAL_FRAME_PULSE);
        repeat (2) @(posedge MCLK);
    endtask
    // ********************
    // Scenarios
    // ********************
    task t_reset;
        rc(4'h0, 32'h8000);
        rc(4'h8, 32'h0);
        rc(4'hC, 32'h0);
        chk(SCLK_OE, 1'b0);
    endtask
    task t_codec;
        bus(1'b1, 4'h0, 32'h9000);
        bus(1'b1, 4'h4, 32'h8021);
        rc(4'h4, 32'h7F);
        bus(1'b1, 4'h0, 32'hD000);
        bus(1'b1, 4'h4, 32'h0);
        rc(4'h4, 32'hD5);
        bus(1'b1, 4'h0, 32'hA000);
        bus(1'b1, 4'h4, 32'h11);
        bus(1'b1, 4'h4, 32'hFF);
        rc(4'h4, 32'h0021);
    endtask
    task t_serial;
        bus(1'b1, 4'h0, 32'h8000);
        bus(1'b1, 4'h4, 32'hA5);
        bus(1'b1, 4'h4, 32'h3C);
        upper(32'h000A);
        nxt;
        nxt;
        repeat (95) @(posedge MCLK);
        chk(cap0, 8'h3C);
        chk(cap1, 8'hA5);
        rc(4'h4, 32'h96);
        rc(4'h4, 32'h5A);
        rc(4'h0, 32'h0A08);
        chk(per, 120);
        chk(wid, 10);
    endtask
    task t_rate;
        nxt;
        upper(32'h0004);
        nxt;
        chk(per, 120);
        nxt;
        chk(per, 60);
        for (int c = 1; c < 8; c++) begin
            upper(32'h4 | (c << 8));
            nxt;
            nxt;
            chk(per, 6 * ((c < 4) ? 10 + 2 * c : 4 * c + 4));
        end
        upper(32'h1708);
        nxt;
        nxt;
        chk(wid, 256);
        chk(per, 320);
    endtask
    // External frames, then the same with the serial enable cleared
    task t_ext(input [31:0] ctrl, input on);
        bus(1'b1, 4'h0, ctrl);
        repeat (320) @(posedge MCLK);
        oe0 = oe_hits;
        EXT_RX_FRAME_N <= 1'b0;
        EXT_TX_FRAME_N <= 1'b0;
        repeat (300) @(posedge MCLK);
        EXT_RX_FRAME_N <= 1'b1;
        EXT_TX_FRAME_N <= 1'b1;
        repeat (20) @(posedge MCLK);
        chk(oe_hits > oe0, on);
        bus(1'b0, 4'h0, 32'h0);
        chk(rdv[1], 1'b1);
        bus(1'b1, 4'h0, ctrl);
    endtask
    task end_of_test;
        $display("mismatches %0d cmp_count %0d", mismatches, cmp_count);
        if (mismatches == 0 && cmp_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    initial begin
        {RST_N, AVS_READ, AVS_WRITE, SCLK_I} = 4'h0;
        {EXT_RX_FRAME_N, EXT_TX_FRAME_N} = 2'h3;
        AVS_ADDRESS = 4'h0;
        AVS_WRITEDATA = 32'h0;
        repeat (4) @(posedge MCLK);
        RST_N <= 1'b1;
        t_reset;
        t_codec;
        t_serial;
        t_rate;
        t_ext(32'h0800, 1'b1);
        t_ext(32'h0000, 1'b0);
        end_of_test;
    end
    // Watchdog at 20000 MCLK cycles, about five times the scenarios' length
    initial begin
        #2000000;
        mismatches = mismatches + 1;
        end_of_test;
    end
endmodule // dpsp_top_test
